//--- hw/tmc_decode.sv
// Mode decode from pins and calibration field
`timescale 1ns/10ps
module tmc_decode (
	// Inputs
	input wire tmc_pkg::tmc_pins_t pins,
	input wire logic [1:0] cal_sel,
	// Result
	output tmc_pkg::tmc_mode_t mode
);
	import tmc_pkg::*;

	// Pin pair first, calibration field picks variants
	always_comb begin
		case ({pins.power_on_pin, pins.tx_select_pin})
			2'h0: mode = TMC_SHUTDOWN;
			2'h1: mode = TMC_STANDBY;
			2'h2: mode = cal_sel[TMC_CAL_RX_BIT] ? TMC_RX_CAL : TMC_RX;
			2'h3: mode = cal_sel[TMC_CAL_TX_BIT] ? TMC_TX_CAL : TMC_TX;
			default: mode = TMC_SHUTDOWN;
		endcase
	end
endmodule : tmc_decode

//--- hw/tmc_top.sv
// Operating mode control for the radio transceiver
`timescale 1ns/10ps
// Functional notes
// - Both mode pins low: shutdown, only serial interface and registers stay live.
// - Power-on low, tx-select high: standby, synthesizer and LO stay on.
// - Power-on high, tx-select low: complete receive path enabled.
// - Both pins high: complete transmit path enabled.
// - Tx calibration: tx on except PA driver; detector routed to rx outputs.
// - Rx calibration: tx loop into rx inputs, synth on, LNA off.
module tmc_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Mode pins from the controller
	input wire tmc_pkg::tmc_pins_t pins,
	// Calibration field from the register file
	input wire logic [1:0] cal_sel,
	// Register file write strobe, seen in every mode
	input wire logic reg_wr,
	// Outputs
	output tmc_pkg::tmc_mode_t mode,
	output tmc_pkg::tmc_enables_t en,
	output logic reg_wr_ack
);
	import tmc_pkg::*;

	typedef struct packed {
		tmc_mode_t mode;
		tmc_enables_t en;
		logic ack;
	} tmc_state_t;

	tmc_state_t s_q;
	tmc_state_t s_d;
	tmc_mode_t mode_dec;

	// Pin and field decode
	tmc_decode u_dec (
		.pins(pins),
		.cal_sel(cal_sel),
		.mode(mode_dec)
	);

	// Next state: enables per mode
	always_comb begin
		s_d = s_q;
		s_d.mode = mode_dec;
		s_d.en = TMC_EN_OFF;
		// Serial port and registers live in every mode
		s_d.en.serial_en = 1'h1;
		// Write strobe answered even in shutdown
		s_d.ack = reg_wr;
		case (mode_dec)
			TMC_SHUTDOWN: begin
				s_d.en.serial_en = 1'h1;
			end
			TMC_STANDBY: begin
				s_d.en.synth_en = 1'h1;
			end
			TMC_RX: begin
				s_d.en.synth_en = 1'h1;
				s_d.en.lna_en = 1'h1;
				s_d.en.rx_path_en = 1'h1;
				s_d.en.rx_iq_buf_en = 1'h1;
			end
			TMC_TX: begin
				s_d.en.synth_en = 1'h1;
				s_d.en.tx_upconv_en = 1'h1;
				s_d.en.tx_path_en = 1'h1;
				s_d.en.pa_drv_en = 1'h1;
			end
			TMC_RX_CAL: begin
				s_d.en.synth_en = 1'h1;
				s_d.en.rx_path_en = 1'h1;
				s_d.en.rx_iq_buf_en = 1'h1;
				s_d.en.tx_upconv_en = 1'h1;
				s_d.en.cal_tone_en = 1'h1;
				s_d.en.loopback_en = 1'h1;
			end
			TMC_TX_CAL: begin
				s_d.en.synth_en = 1'h1;
				s_d.en.tx_upconv_en = 1'h1;
				s_d.en.tx_path_en = 1'h1;
				s_d.en.am_det_en = 1'h1;
				s_d.en.rx_iq_buf_en = 1'h1;
				s_d.en.rx_mux_det = 1'h1;
			end
			// Unused codes fall back to shutdown
			default: begin
				s_d.mode = TMC_SHUTDOWN;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{mode: TMC_SHUTDOWN, en: TMC_EN_OFF, ack: 1'h0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign mode = s_q.mode;
	assign en = s_q.en;
	assign reg_wr_ack = s_q.ack;

	// Pin pairs, and the power-on pin alone, as seen at an edge
	sequence s_pins_off;
		!pins.power_on_pin && !pins.tx_select_pin;
	endsequence
	sequence s_pins_standby;
		!pins.power_on_pin && pins.tx_select_pin;
	endsequence
	sequence s_pins_rx;
		pins.power_on_pin && !pins.tx_select_pin;
	endsequence
	sequence s_pins_tx;
		pins.power_on_pin && pins.tx_select_pin;
	endsequence
	sequence s_pins_active;
		pins.power_on_pin;
	endsequence

	// Checks
	property p_shutdown;
		@(posedge clk) disable iff (!rst_n)
		(!pins.power_on_pin && !pins.tx_select_pin) |=>
		(mode == TMC_SHUTDOWN && en.serial_en && !en.synth_en);
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("shutdown wrong");

	property p_wr_live;
		@(posedge clk) disable iff (!rst_n)
		(reg_wr && !pins.power_on_pin) |=> reg_wr_ack;
	endproperty
	a_wr_live: assert property (p_wr_live) else $error("write lost");

	property p_standby;
		@(posedge clk) disable iff (!rst_n)
		(!pins.power_on_pin && pins.tx_select_pin) |=>
		(en.synth_en && !en.rx_path_en && !en.tx_path_en);
	endproperty
	a_standby: assert property (p_standby) else $error("standby wrong");

	property p_rx;
		@(posedge clk) disable iff (!rst_n)
		(pins == 2'h2 && !cal_sel[TMC_CAL_RX_BIT]) |=>
		(mode == TMC_RX && en.lna_en && en.rx_path_en && !en.tx_path_en);
	endproperty
	a_rx: assert property (p_rx) else $error("rx wrong");

	property p_tx;
		@(posedge clk) disable iff (!rst_n)
		(pins == 2'h3 && !cal_sel[TMC_CAL_TX_BIT]) |=>
		(mode == TMC_TX && en.pa_drv_en && !en.rx_path_en);
	endproperty
	a_tx: assert property (p_tx) else $error("tx wrong");

	property p_txcal;
		@(posedge clk) disable iff (!rst_n)
		(pins == 2'h3 && cal_sel[TMC_CAL_TX_BIT]) |=>
		(!en.pa_drv_en && en.am_det_en && en.rx_mux_det && en.tx_path_en &&
		en.tx_upconv_en && en.rx_iq_buf_en && !en.lna_en && mode == TMC_TX_CAL);
	endproperty
	a_txcal: assert property (p_txcal) else $error("tx cal wrong");

	property p_rxcal;
		@(posedge clk) disable iff (!rst_n)
		(pins == 2'h2 && cal_sel[TMC_CAL_RX_BIT]) |=>
		(!en.lna_en && en.loopback_en && en.synth_en && en.rx_path_en &&
		en.tx_upconv_en && en.cal_tone_en && !en.pa_drv_en &&
		mode == TMC_RX_CAL);
	endproperty
	a_rxcal: assert property (p_rxcal) else $error("rx cal wrong");

	sequence s_pins_stable;
		$stable(pins) && $stable(cal_sel);
	endsequence
	property p_cal_follow;
		@(posedge clk) disable iff (!rst_n)
		(pins.power_on_pin && cal_sel == TMC_CAL_NONE) ##1 s_pins_stable |=>
		(mode == TMC_RX || mode == TMC_TX);
	endproperty
	a_cal_follow: assert property (p_cal_follow) else $error("plain mode");

	// Exact power sets, write echo and mode entry
	property p_off_quiet;
		@(posedge clk) disable iff (!rst_n)
		s_pins_off |=> ($countones(en) == 1 && en.serial_en);
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("block powered in shutdown");

	property p_serial_live;
		@(posedge clk) disable iff (!rst_n)
		1'h1 |=> en.serial_en;
	endproperty
	a_serial_live: assert property (p_serial_live)
		else $error("serial side powered down");

	property p_wr_echo;
		@(posedge clk) disable iff (!rst_n)
		1'h1 |=> (reg_wr_ack == $past(reg_wr));
	endproperty
	a_wr_echo: assert property (p_wr_echo)
		else $error("write strobe not answered");

	property p_standby_quiet;
		@(posedge clk) disable iff (!rst_n)
		s_pins_standby |=> (mode == TMC_STANDBY && $countones(en) == 2 &&
		en.synth_en && en.serial_en);
	endproperty
	a_standby_quiet: assert property (p_standby_quiet)
		else $error("extra block powered in standby");

	property p_quick_start;
		@(posedge clk) disable iff (!rst_n)
		s_pins_standby ##1 s_pins_active |=>
		(en.synth_en && $past(en.synth_en));
	endproperty
	a_quick_start: assert property (p_quick_start)
		else $error("synthesizer dropped leaving standby");

	property p_rx_plain;
		@(posedge clk) disable iff (!rst_n)
		(s_pins_rx ##0 !cal_sel[TMC_CAL_RX_BIT]) |=>
		(!en.cal_tone_en && !en.loopback_en && !en.am_det_en &&
		!en.pa_drv_en && !en.tx_upconv_en && en.rx_iq_buf_en);
	endproperty
	a_rx_plain: assert property (p_rx_plain)
		else $error("calibration block on in receive");

	property p_tx_plain;
		@(posedge clk) disable iff (!rst_n)
		(s_pins_tx ##0 !cal_sel[TMC_CAL_TX_BIT]) |=>
		(!en.am_det_en && !en.rx_mux_det && !en.lna_en &&
		!en.rx_iq_buf_en && en.tx_upconv_en && en.synth_en);
	endproperty
	a_tx_plain: assert property (p_tx_plain)
		else $error("calibration block on in transmit");

	property p_idle_no_cal;
		@(posedge clk) disable iff (!rst_n)
		(!pins.power_on_pin) |=> (!en.am_det_en && !en.cal_tone_en &&
		!en.loopback_en && !en.rx_mux_det && mode != TMC_RX_CAL &&
		mode != TMC_TX_CAL);
	endproperty
	a_idle_no_cal: assert property (p_idle_no_cal)
		else $error("calibration field used while idle");
endmodule : tmc_top

//--- shared/tmc_pkg.sv
// Package for the transceiver mode control block
package tmc_pkg;
	// Calibration select field (two bits, from register 6 in the device)
	localparam int TMC_CAL_W = 2;
	localparam logic [1:0] TMC_CAL_NONE = 2'h0;
	localparam int TMC_CAL_RX_BIT = 0;
	localparam int TMC_CAL_TX_BIT = 1;
	// Power detector gain field value for 9 dB (arbitrary code, two bits)
	localparam logic [1:0] TMC_PDET_GAIN_9DB = 2'h1;

	// Operating modes, one-hot
	typedef enum logic [5:0] {
		TMC_SHUTDOWN = 6'h01,
		TMC_STANDBY = 6'h02,
		TMC_RX = 6'h04,
		TMC_TX = 6'h08,
		TMC_RX_CAL = 6'h10,
		TMC_TX_CAL = 6'h20
	} tmc_mode_t;

	// Mode pin pair
	typedef struct packed {
		logic power_on_pin;
		logic tx_select_pin;
	} tmc_pins_t;

	// Block power and routing enables
	typedef struct packed {
		logic synth_en;     // PLL, VCO, LO generators, auto tuner
		logic lna_en;
		logic rx_path_en;   // rest of receive path
		logic tx_upconv_en;
		logic tx_path_en;   // tx baseband, filter
		logic pa_drv_en;    // PA driver and external PA
		logic am_det_en;
		logic rx_iq_buf_en;
		logic rx_mux_det;   // rx outputs carry detector signal
		logic cal_tone_en;  // tone, RF phase shift, loopback into rx
		logic loopback_en;
		logic serial_en;    // serial interface and register file
	} tmc_enables_t;

	localparam tmc_enables_t TMC_EN_OFF = '0;
endpackage : tmc_pkg

//--- test/tmc_ctrl_model.sv
// Controller model driving the mode pins and register write strobe
`timescale 1ns/10ps
module tmc_ctrl_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Drives into the block
	output tmc_pkg::tmc_pins_t pins,
	output logic [1:0] cal_sel,
	output logic reg_wr
);
	import tmc_pkg::*;
	integer seed;
	// Register 0 write, tx calibration entry, then random traffic
	initial begin
		seed = 24;
		pins = '0;
		cal_sel = TMC_CAL_NONE;
		reg_wr = 1'h0;
		// Bounded wait for the end of power-up reset
		for (int i = 0; i < 64 && rst_n !== 1'h1; i++) begin
			@(posedge clk);
		end
		#1 reg_wr = 1'h1;
		@(posedge clk);
		#1 reg_wr = 1'h0;
		pins = 2'h3;
		cal_sel = 2'h2;
		repeat (4) @(posedge clk);
		forever begin
			#1 {pins, cal_sel, reg_wr} = 5'($random(seed));
			@(posedge clk);
		end
	end
endmodule : tmc_ctrl_model

//--- test/transceiver_mode_control_tb.sv
// Self-checking bench for the transceiver mode control block
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
	fail_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module transceiver_mode_control_tb;
	import tmc_pkg::*;
	logic clk = 1'h0;
	logic rst_n;
	tmc_pins_t pins;
	logic [1:0] cal_sel;
	logic reg_wr;
	tmc_mode_t mode;
	tmc_enables_t en;
	logic reg_wr_ack;
	integer fail_count = 0;
	integer total_checks = 0;
	logic [30:0] exp_q[$];
	logic [30:0] e;
	// Expected mode, enables, care mask and ack from the pin levels, calibration field and write strobe
	function automatic logic [30:0] model(logic [1:0] p, logic [1:0] c,
		logic w);
		case (p)
			2'h0: return {6'h01, 12'h001, 12'hfff, w};
			2'h1: return {6'h02, 12'h801, 12'hfff, w};
			2'h2: return c[TMC_CAL_RX_BIT] ? {6'h10, 12'hb07, 12'hf6f, w}
				: {6'h04, 12'he11, 12'hfff, w};
			default: return c[TMC_CAL_TX_BIT] ? {6'h20, 12'h9b9, 12'hfff, w}
				: {6'h08, 12'h9c1, 12'hfff, w};
		endcase
	endfunction : model
	// Verdict and end of run
	task automatic end_of_test();
		if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	always #5 clk = ~clk;
	tmc_ctrl_model i_ctrl (
		.clk(clk), .rst_n(rst_n), .pins(pins), .cal_sel(cal_sel),
		.reg_wr(reg_wr)
	);
	tmc_top i_dut (
		.clk(clk), .rst_n(rst_n), .pins(pins), .cal_sel(cal_sel),
		.reg_wr(reg_wr), .mode(mode), .en(en), .reg_wr_ack(reg_wr_ack)
	);
	// Expectation taken at each edge, compared once outputs settle
	always @(posedge clk) begin
		if (rst_n) exp_q.push_back(model(pins, cal_sel, reg_wr));
		#4;
		if (!rst_n) begin
			exp_q.delete();
			`CHK("rst mode", TMC_SHUTDOWN, mode)
			`CHK("rst en", TMC_EN_OFF, en)
			`CHK("rst ack", 1'h0, reg_wr_ack)
		end else if (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			`CHK("mode", e[30:25], mode)
			`CHK("en", e[24:13] & e[12:1], en & e[12:1])
			`CHK("ack", e[0], reg_wr_ack)
		end
	end
	// Reset, run, reset again in mid-run, run
	initial begin
		rst_n = 1'h0;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'h1;
		repeat (300) @(posedge clk);
		#1 rst_n = 1'h0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'h1;
		repeat (300) @(posedge clk);
		end_of_test();
	end
endmodule : transceiver_mode_control_tb
